// *** design/spgi_top.v ***
// frame receiver, command interpreter and reply shifter of the sensor programming link
`timescale 1ns/1ps
`include "spgi_defines.vh"
module spgi_top #(
    parameter [31:0] START_CYC  = `SPGI_START_CYC,
    parameter        FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire        clock_in,
    input  wire        rst_n_in,
    // programming link pins
    input  wire        supply_clk_in,
    input  wire        data_pin_in,
    output wire        data_pin_out,
    output wire        data_pin_oe_n_out,
    // application output level
    input  wire        app_data_in,
    // register read port
    output wire [5:0]  mem_rd_addr_out,
    input  wire [15:0] mem_rd_data_in,
    // register write stream
    output wire        mem_wr_valid_out,
    input  wire        mem_wr_ready_in,
    output wire [5:0]  mem_wr_addr_out,
    output wire [15:0] mem_wr_data_out,
    // mode status
    output wire        prog_mode_out,
    output wire        locked_out,
    output wire        nv_write_mode_out,
    output wire        nv_erase_mode_out,
    output wire        margin_mode_out,
    output wire        refresh_out
);
    // ****************************************
    // states
    // ****************************************
    localparam [5:0] ST_APP  = 6'h01;
    localparam [5:0] ST_RX   = 6'h02;
    localparam [5:0] ST_EVAL = 6'h04;
    localparam [5:0] ST_PUSH = 6'h08;
    localparam [5:0] ST_PREP = 6'h10;
    localparam [5:0] ST_TX   = 6'h20;

    // ****************************************
    // frame checks
    // ****************************************
    // frame bits set
    function frame_ok;
        input [20:0] f;
        begin
            frame_ok = f[0] && f[20] && !(^(f & `SPGI_EVEN_MASK)) && !(^(f & `SPGI_ODD_MASK));
        end
    endfunction

    function cmd_ok;
        input [20:0] f;
        reg   [5:0]  c;
        begin
            c      = f[`SPGI_CMD_MSB:`SPGI_CMD_LSB];
            cmd_ok = !f[7] && f[8] && !f[15] && !f[16] && f[`SPGI_BIT_KIND] &&
                     (c <= `SPGI_CMD_RD_INC || (c >= `SPGI_CMD_WR_SINGLE && c <= `SPGI_CMD_REFRESH));
        end
    endfunction

    reg  [5:0]  state_ff;
    reg  [5:0]  nxt_state;
    reg  [4:0]  cnt_ff;
    reg  [4:0]  nxt_cnt;
    reg  [20:0] sr_ff;
    reg  [20:0] nxt_sr;
    reg  [5:0]  addr_ff;
    reg  [5:0]  nxt_addr;
    reg  [1:0]  rd_mode_ff;
    reg  [1:0]  nxt_rd_mode;
    reg  [1:0]  wr_mode_ff;
    reg  [1:0]  nxt_wr_mode;
    reg  [15:0] wdata_ff;
    reg  [15:0] nxt_wdata;
    reg         first_ff;
    reg         nxt_first;
    reg         prog_ff;
    reg         nxt_prog;
    reg         locked_ff;
    reg         nxt_locked;
    reg         nvw_ff;
    reg         nxt_nvw;
    reg         ers_ff;
    reg         nxt_ers;
    reg         mrg_ff;
    reg         nxt_mrg;
    reg         rfr_ff;
    reg         nxt_rfr;
    reg         settle_ff;
    reg         nxt_settle;
    reg         dout_ff;
    reg         nxt_dout;
    reg         oe_n_ff;
    reg         nxt_oe_n;
    reg  [31:0] win_cnt_ff;
    reg         win_done_ff;
    reg         sclk_d_ff;
    reg         push;
    wire [1:0]  pins_sync;
    wire        sclk;
    wire        sdat;
    wire        edge_rise;
    wire        fifo_ready;
    wire        fifo_valid;
    wire [5:0]  f_code;

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    spgi_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in ({supply_clk_in, data_pin_in}),
        .sync_out (pins_sync)
    );

    assign sclk      = pins_sync[1];
    assign sdat      = pins_sync[0];
    // one bit per rising supply edge
    assign edge_rise = sclk && !sclk_d_ff;
    assign f_code    = sr_ff[`SPGI_CMD_MSB:`SPGI_CMD_LSB];

    // ****************************************
    // write stream buffer
    // ****************************************
    // full buffer stalls the push state; the gap between frames covers it
    spgi_fifo #(
        .WIDTH (22),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({addr_ff, wdata_ff}),
        .out_valid_out (fifo_valid),
        .out_ready_in  (mem_wr_ready_in),
        .out_data_out  ({mem_wr_addr_out, mem_wr_data_out})
    );

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_sr      = sr_ff;
        nxt_addr    = addr_ff;
        nxt_rd_mode = rd_mode_ff;
        nxt_wr_mode = wr_mode_ff;
        nxt_wdata   = wdata_ff;
        nxt_first   = first_ff;
        nxt_prog    = prog_ff;
        nxt_locked  = locked_ff;
        nxt_nvw     = nvw_ff;
        nxt_ers     = ers_ff;
        nxt_mrg     = mrg_ff;
        nxt_rfr     = 1'b0;
        nxt_settle  = settle_ff;
        nxt_dout    = dout_ff;
        nxt_oe_n    = oe_n_ff;
        push        = 1'b0;
        case (state_ff)
            ST_RX: begin
                if (first_ff && win_done_ff && cnt_ff == 5'h00) begin
                    nxt_state  = ST_APP;
                    nxt_locked = 1'b1;
                end else if (edge_rise) begin
                    nxt_sr = {sdat, sr_ff[20:1]};
                    if (cnt_ff == `SPGI_LAST_BIT_CNT) begin
                        nxt_cnt   = 5'h00;
                        nxt_state = ST_EVAL;
                    end else begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                end
            end
            ST_EVAL: begin
                nxt_state = ST_RX;
                if (!frame_ok(sr_ff)) begin
                    nxt_state  = ST_APP;
                    nxt_locked = 1'b1;
                    nxt_prog   = 1'b0;
                end else if (sr_ff[`SPGI_BIT_KIND]) begin
                    nxt_nvw     = 1'b0;
                    nxt_ers     = 1'b0;
                    nxt_mrg     = 1'b0;
                    nxt_wr_mode = `SPGI_MODE_NONE;
                    nxt_first   = 1'b0;
                    nxt_prog    = 1'b1;
                    nxt_addr    = sr_ff[`SPGI_ADDR_MSB:`SPGI_ADDR_LSB];
                    if (!cmd_ok(sr_ff) || f_code == `SPGI_CMD_EXIT) begin
                        nxt_state  = ST_APP;
                        nxt_locked = 1'b1;
                        nxt_prog   = 1'b0;
                    end else if (f_code <= `SPGI_CMD_RD_INC) begin
                        nxt_rd_mode = f_code[1:0];
                        nxt_settle  = 1'b0;
                        nxt_state   = ST_PREP;
                    end else if (f_code <= `SPGI_CMD_WR_INC) begin
                        nxt_wr_mode = f_code[1:0];
                    end else if (f_code == `SPGI_CMD_NV_WRITE) begin
                        nxt_nvw = 1'b1;
                    end else if (f_code == `SPGI_CMD_NV_ERASE) begin
                        nxt_ers = 1'b1;
                    end else if (f_code == `SPGI_CMD_MARGIN) begin
                        nxt_mrg = 1'b1;
                    end else begin
                        nxt_rfr = 1'b1;
                    end
                end else if (first_ff || wr_mode_ff == `SPGI_MODE_NONE) begin
                    nxt_state  = ST_APP;
                    nxt_locked = 1'b1;
                    nxt_prog   = 1'b0;
                end else begin
                    nxt_wdata = sr_ff[`SPGI_DATA_MSB:`SPGI_DATA_LSB];
                    nxt_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                push = 1'b1;
                if (fifo_ready) begin
                    nxt_state = ST_RX;
                    if (wr_mode_ff == `SPGI_MODE_SINGLE) begin
                        nxt_wr_mode = `SPGI_MODE_NONE;
                    end else if (wr_mode_ff == `SPGI_MODE_INC) begin
                        if (addr_ff[2:0] == `SPGI_BLOCK_END) begin
                            nxt_wr_mode = `SPGI_MODE_NONE;
                        end else begin
                            nxt_addr = addr_ff + 6'h01;
                        end
                    end
                end
            end
            ST_PREP: begin
                // reads wait until queued writes have landed
                if (!fifo_valid) begin
                    nxt_settle = 1'b1;
                    if (settle_ff) begin
                        nxt_sr     = {1'b1, addr_ff[2:0], mem_rd_data_in, 1'b1};
                        nxt_cnt    = 5'h00;
                        nxt_settle = 1'b0;
                        nxt_state  = ST_TX;
                    end
                end
            end
            ST_TX: begin
                if (edge_rise) begin
                    nxt_dout = sr_ff[0];
                    nxt_sr   = {1'b1, sr_ff[20:1]};
                    if (cnt_ff == `SPGI_LAST_BIT_CNT) begin
                        nxt_cnt = 5'h00;
                        if (rd_mode_ff == `SPGI_MODE_CONT) begin
                            nxt_state = ST_PREP;
                        end else if (rd_mode_ff == `SPGI_MODE_INC && addr_ff[2:0] != `SPGI_BLOCK_END) begin
                            nxt_addr  = addr_ff + 6'h01;
                            nxt_state = ST_PREP;
                        end else begin
                            nxt_rd_mode = `SPGI_MODE_NONE;
                            nxt_state   = ST_RX;
                        end
                    end else begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                end
            end
            ST_APP: begin
                nxt_state = ST_APP;
            end
            default: begin
                nxt_state  = ST_APP;
                nxt_locked = 1'b1;
                nxt_prog   = 1'b0;
            end
        endcase
        // ****************************************
        // pin driver
        // ****************************************
        if (nxt_state == ST_APP || nxt_first) begin
            nxt_oe_n = 1'b0;
            nxt_dout = app_data_in;
        end else if (nxt_state == ST_RX && nxt_cnt != 5'h00) begin
            nxt_oe_n = 1'b1;
        end else if (nxt_state != ST_TX) begin
            nxt_oe_n = 1'b0;
            nxt_dout = 1'b1;
        end else begin
            nxt_oe_n = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff    <= ST_RX;
            cnt_ff      <= 5'h00;
            sr_ff       <= 21'h000000;
            addr_ff     <= 6'h00;
            rd_mode_ff  <= 2'h0;
            wr_mode_ff  <= 2'h0;
            wdata_ff    <= 16'h0000;
            first_ff    <= 1'b1;
            prog_ff     <= 1'b0;
            locked_ff   <= 1'b0;
            nvw_ff      <= 1'b0;
            ers_ff      <= 1'b0;
            mrg_ff      <= 1'b0;
            rfr_ff      <= 1'b0;
            settle_ff   <= 1'b0;
            dout_ff     <= 1'b1;
            oe_n_ff     <= 1'b0;
            sclk_d_ff   <= 1'b0;
            win_cnt_ff  <= 32'h00000000;
            win_done_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            sr_ff       <= nxt_sr;
            addr_ff     <= nxt_addr;
            rd_mode_ff  <= nxt_rd_mode;
            wr_mode_ff  <= nxt_wr_mode;
            wdata_ff    <= nxt_wdata;
            first_ff    <= nxt_first;
            prog_ff     <= nxt_prog;
            locked_ff   <= nxt_locked;
            nvw_ff      <= nxt_nvw;
            ers_ff      <= nxt_ers;
            mrg_ff      <= nxt_mrg;
            rfr_ff      <= nxt_rfr;
            settle_ff   <= nxt_settle;
            dout_ff     <= nxt_dout;
            oe_n_ff     <= nxt_oe_n;
            sclk_d_ff   <= sclk;
            if (!win_done_ff) begin
                win_cnt_ff <= win_cnt_ff + 32'h00000001;
                if (win_cnt_ff == START_CYC - 32'h00000001) begin
                    win_done_ff <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign data_pin_out      = dout_ff;
    assign data_pin_oe_n_out = oe_n_ff;
    assign mem_rd_addr_out   = addr_ff;
    assign mem_wr_valid_out  = fifo_valid;
    assign prog_mode_out     = prog_ff;
    assign locked_out        = locked_ff;
    assign nv_write_mode_out = nvw_ff;
    assign nv_erase_mode_out = ers_ff;
    assign margin_mode_out   = mrg_ff;
    assign refresh_out       = rfr_ff;
endmodule

// *** common/spgi_defines.vh ***
// frame layout, command codes and timing constants of the sensor programming link
`ifndef SPGI_DEFINES_VH
`define SPGI_DEFINES_VH

// ****************************************
// frame layout
// ****************************************
`define SPGI_FRAME_BITS      5'h15
`define SPGI_LAST_BIT_CNT    5'h14
`define SPGI_BIT_EVEN_PAR    17
`define SPGI_BIT_ODD_PAR     18
`define SPGI_BIT_KIND        19
`define SPGI_EVEN_MASK       21'h155555
`define SPGI_ODD_MASK        21'h0AAAAA
`define SPGI_CMD_MSB         6
`define SPGI_CMD_LSB         1
`define SPGI_ADDR_MSB        14
`define SPGI_ADDR_LSB        9
`define SPGI_DATA_MSB        16
`define SPGI_DATA_LSB        1

// ****************************************
// command codes
// ****************************************
`define SPGI_CMD_EXIT        6'h00
`define SPGI_CMD_RD_SINGLE   6'h01
`define SPGI_CMD_RD_CONT     6'h02
`define SPGI_CMD_RD_INC      6'h03
`define SPGI_CMD_WR_SINGLE   6'h09
`define SPGI_CMD_WR_CONT     6'h0A
`define SPGI_CMD_WR_INC      6'h0B
`define SPGI_CMD_NV_WRITE    6'h0C
`define SPGI_CMD_NV_ERASE    6'h0D
`define SPGI_CMD_MARGIN      6'h0E
`define SPGI_CMD_REFRESH     6'h0F

// ****************************************
// access modes and timing
// ****************************************
`define SPGI_MODE_NONE       2'h0
`define SPGI_MODE_SINGLE     2'h1
`define SPGI_MODE_CONT       2'h2
`define SPGI_MODE_INC        2'h3
`define SPGI_BLOCK_END       3'h7
`define SPGI_START_TIME_US   19000
`define SPGI_CLK_MHZ         100
`define SPGI_START_CYC       (`SPGI_START_TIME_US * `SPGI_CLK_MHZ)

`endif

// *** design/spgi_sync.v ***
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module spgi_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             rst_n_in,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // ****************************************
    // first stage feeds only the second
    // ****************************************
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// *** design/spgi_fifo.v ***
// shifting word fifo with valid/ready on both sides; head word is a flop
`timescale 1ns/1ps
module spgi_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 4
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             rst_n_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    localparam CW = $clog2(DEPTH + 1);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [CW-1:0]    cnt_ff;
    reg             valid_ff;
    reg             ready_ff;
    wire            push;
    wire            pop;
    wire [CW-1:0]   nxt_cnt;
    wire [CW-1:0]   wr_idx;
    integer         i;

    assign push    = in_valid_in && ready_ff;
    assign pop     = valid_ff && out_ready_in;
    assign nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
    assign wr_idx  = cnt_ff - {{(CW-1){1'b0}}, pop};

    // ****************************************
    // storage shifts toward index zero on pop
    // ****************************************
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
            cnt_ff   <= {CW{1'b0}};
            valid_ff <= 1'b0;
            ready_ff <= 1'b1;
        end else begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (push && (wr_idx == i[CW-1:0])) begin
                    mem_ff[i] <= in_data_in;
                end else if (pop) begin
                    mem_ff[i] <= (i + 1 < DEPTH) ? mem_ff[(i + 1) % DEPTH] : {WIDTH{1'b0}};
                end
            end
            cnt_ff   <= nxt_cnt;
            valid_ff <= (nxt_cnt != {CW{1'b0}});
            ready_ff <= (nxt_cnt != DEPTH[CW-1:0]);
        end
    end

    assign in_ready_out  = ready_ff;
    assign out_valid_out = valid_ff;
    assign out_data_out  = mem_ff[0];
endmodule

// *** tb/spgi_checker.sv ***
// concurrent checks on the programming link ports
`timescale 1ns/1ps
module spgi_checker (
    // clock and reset
    input logic        clock_in,
    input logic        rst_n_in,
    // pins and status
    input logic        supply_clk_in,
    input logic        app_data_in,
    input logic        data_pin_out,
    input logic        data_pin_oe_n_out,
    input logic        mem_wr_valid_out,
    input logic        mem_wr_ready_in,
    input logic [21:0] mem_wr_word,
    input logic        prog_mode_out,
    input logic        locked_out,
    input logic [2:0]  modes,
    input logic        refresh_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // ****
    // link and stream rules
    // ****
    sequence s_stall;
        mem_wr_valid_out && !mem_wr_ready_in;
    endsequence
    // two application cycles; the first after reset still shows the reset value
    sequence s_app;
        !prog_mode_out && !$past(prog_mode_out) && $past(rst_n_in);
    endsequence
    a_lock_app_mode: assert property (locked_out |-> !prog_mode_out && !data_pin_oe_n_out)
        else $error("locked but not in app mode");
    a_lock_stays_on: assert property (locked_out |=> locked_out)
        else $error("lock released");
    a_app_pin_drive: assert property (s_app |-> !data_pin_oe_n_out && data_pin_out == $past(app_data_in))
        else $error("app level not driven");
    // edge seen 2 cycles after the supply rises; the driver flop moves one cycle later
    a_rx_driver_off: assert property ($rose(data_pin_oe_n_out) |-> prog_mode_out && $past(supply_clk_in, 3))
        else $error("driver off without edge");
    a_reply_on_edge: assert property ($changed(data_pin_out) && prog_mode_out && $past(prog_mode_out)
        && !data_pin_oe_n_out && !$past(data_pin_oe_n_out) |-> $past(supply_clk_in, 3))
        else $error("reply bit moved without edge");
    a_refresh_pulse: assert property (refresh_out |=> !refresh_out)
        else $error("refresh pulse too long");
    a_mode_one_hot: assert property ($onehot0(modes))
        else $error("several memory modes on");
    a_wr_word_hold: assert property (s_stall |=> mem_wr_valid_out && $stable(mem_wr_word))
        else $error("write word lost in stall");
endmodule
bind spgi_top spgi_checker i_spgi_checker (.clock_in, .rst_n_in, .supply_clk_in, .app_data_in, .data_pin_out,
    .data_pin_oe_n_out, .mem_wr_valid_out, .mem_wr_ready_in, .mem_wr_word({mem_wr_addr_out, mem_wr_data_out}),
    .prog_mode_out, .locked_out, .modes({nv_write_mode_out, nv_erase_mode_out, margin_mode_out}), .refresh_out);

// *** tb/spgi_prog_model.sv ***
// behavioural programmer clocking the supply line and driving or reading the data pin
`timescale 1ns/1ps
module spgi_prog_model (
    // clock
    input  logic clock_in,
    // link pins
    input  logic pin_in,
    output logic supply_clk_out,
    output logic drv_en_out,
    output logic drv_val_out
);
    initial begin
        supply_clk_out = 1'b0;
        drv_en_out = 1'b0;
        drv_val_out = 1'b1;
    end
    // 21 bits, lsb first, one per 160 ns supply period (80 ns high)
    task automatic xfer(input logic [20:0] f, input logic rx, output logic [20:0] r);
        for (int i = 0; i < 21; i++) begin
            @(posedge clock_in);
            drv_en_out <= !rx;
            drv_val_out <= f[i];
            repeat (7) @(posedge clock_in);
            supply_clk_out <= 1'b1;
            repeat (7) @(posedge clock_in);
            r[i] = pin_in;
            @(posedge clock_in);
            supply_clk_out <= 1'b0;
        end
        // bits overdrive the pin; release to the pull-up, clock stands low
        @(posedge clock_in);
        drv_en_out <= 1'b0;
        repeat (1000) @(posedge clock_in);
    endtask
endmodule

// *** tb/spgi_test.sv ***
// self-checking bench for the sensor programming link
`timescale 1ns/1ps
module spgi_test;
    // ****
    // signals, helpers and instances
    // ****
    logic        clock_in, rst_n_in, app_data_in, mem_wr_ready_in;
    logic [31:0] lfsr_ff;
    logic [20:0] junk;
    logic [21:0] exp_q[$];
    int          error_cnt, n_checks, n_rfr;
    wire         supply_clk_in, data_pin_in, m_en, m_val, data_pin_out, data_pin_oe_n_out, mem_wr_valid_out;
    wire         prog_mode_out, locked_out, nv_write_mode_out, nv_erase_mode_out, margin_mode_out, refresh_out;
    wire  [5:0]  mem_rd_addr_out, mem_wr_addr_out;
    wire  [15:0] mem_wr_data_out, mem_rd_data_in;
    function automatic logic [15:0] rdv(input logic [5:0] a);
        return {~a, 4'hA, a};
    endfunction
    function automatic logic [31:0] lfsr_nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // parity bits make both positional xors zero
    function automatic logic [20:0] par(input logic [20:0] f);
        f[18] = ^(f & 21'h155555);
        f[17] = ^(f & 21'h0AAAAA);
        return f;
    endfunction
    // open drain: programmer wins, then device driver, else pull-up
    assign data_pin_in = m_en ? m_val : (data_pin_oe_n_out ? 1'b1 : data_pin_out);
    assign mem_rd_data_in = rdv(mem_rd_addr_out);
    spgi_top #(.START_CYC(32'h7D0), .FIFO_DEPTH(4)) i_spgi_top (.clock_in, .rst_n_in, .supply_clk_in, .data_pin_in,
        .data_pin_out, .data_pin_oe_n_out, .app_data_in, .mem_rd_addr_out, .mem_rd_data_in, .mem_wr_valid_out,
        .mem_wr_ready_in, .mem_wr_addr_out, .mem_wr_data_out, .prog_mode_out, .locked_out, .nv_write_mode_out,
        .nv_erase_mode_out, .margin_mode_out, .refresh_out);
    spgi_prog_model i_spgi_prog_model (.clock_in, .pin_in(data_pin_in), .supply_clk_out(supply_clk_in),
        .drv_en_out(m_en), .drv_val_out(m_val));
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [5:0] c, input logic [5:0] a);
        i_spgi_prog_model.xfer(par({4'hC, 2'b00, a, 2'b10, c, 1'b1}), 1'b0, junk);
    endtask
    task automatic wdat(input logic [5:0] a);
        exp_q.push_back({a, lfsr_ff[15:0]});
        i_spgi_prog_model.xfer(par({4'h8, lfsr_ff[15:0], 1'b1}), 1'b0, junk);
    endtask
    task automatic rdat(input logic [5:0] a);
        i_spgi_prog_model.xfer(21'h0, 1'b1, junk);
        chk(junk, {1'b1, a[2:0], rdv(a), 1'b1});
    endtask
    task automatic rst();
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****
    // stimulus, monitor and watchdog
    // ****
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // random pin level and write stalls keep the fifo filling and draining
    always @(posedge clock_in) begin
        lfsr_ff <= lfsr_nxt(lfsr_ff);
        if (rst_n_in && refresh_out)
            n_rfr++;
        app_data_in <= lfsr_ff[3];
        mem_wr_ready_in <= lfsr_ff[7] | lfsr_ff[12];
        if (rst_n_in && mem_wr_valid_out && mem_wr_ready_in)
            chk({mem_wr_addr_out, mem_wr_data_out}, exp_q.size() ? exp_q.pop_front() : 22'hX);
    end
    initial begin
        repeat (80000) @(posedge clock_in);
        error_cnt++;
        summarize();
    end
    initial begin
        rst_n_in = 1'b0;
        app_data_in = 1'b0;
        mem_wr_ready_in = 1'b0;
        lfsr_ff = 32'h1CFA;
        rst();
        cmd(6'h09, 6'h05);
        chk({locked_out, prog_mode_out}, 2'b01);
        wdat(6'h05);
        cmd(6'h01, 6'h05);
        rdat(6'h05);
        cmd(6'h0B, 6'h06);
        wdat(6'h06);
        wdat(6'h07);
        cmd(6'h0A, 6'h02);
        wdat(6'h02);
        wdat(6'h02);
        cmd(6'h03, 6'h15);
        for (int i = 5; i < 8; i++)
            rdat(6'h10 + 6'(i));
        $display("done: writes and reads");
        // no data frames follow the memory mode commands
        for (int c = 12; c < 16; c++) begin
            cmd(6'(c), 6'h00);
            chk({nv_write_mode_out, nv_erase_mode_out, margin_mode_out}, 3'b100 >> (c - 12));
        end
        chk(22'(exp_q.size()), 22'h0);
        chk(22'(n_rfr), 22'h1);
        i_spgi_prog_model.xfer(par({4'hC, 8'h01, 8'h82, 1'b1}) ^ 21'h20000, 1'b0, junk);
        chk({locked_out, prog_mode_out}, 2'b10);
        $display("done: modes and lock");
        rst();
        cmd(6'h02, 6'h04);
        rdat(6'h04);
        rdat(6'h04);
        rst();
        cmd(6'h0F, 6'h00);
        chk(22'(n_rfr), 22'h2);
        cmd(6'h00, 6'h00);
        chk({locked_out, prog_mode_out}, 2'b10);
        rst();
        repeat (2100) @(posedge clock_in);
        chk({locked_out, prog_mode_out}, 2'b10);
        $display("done: restarts");
        summarize();
    end
endmodule
